// ==== gpr_pkg.sv ====
package gpr_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] OFS_CTRL  = 16'hc006;
    localparam logic [15:0] OFS_OUT0  = 16'hc01e;
    localparam logic [15:0] OFS_IN0   = 16'hc020;
    localparam logic [15:0] OFS_DIR0  = 16'hc022;
    localparam logic [15:0] OFS_OUT1  = 16'hc024;
    localparam logic [15:0] OFS_IN1   = 16'hc026;
    localparam logic [15:0] OFS_DIR1  = 16'hc028;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int          BIT_WP     = 15;
    localparam int          BIT_TXR    = 14;
    localparam int          BIT_SAS    = 11;
    localparam int          MODE_LO    = 8;
    localparam int          BIT_HSPIN  = 7;
    localparam int          BIT_HSBUS  = 6;
    localparam int          BIT_SPIPIN = 5;
    localparam int          BIT_SPIBUS = 4;
    localparam int          BIT_POL1   = 3;
    localparam int          BIT_EN1    = 2;
    localparam int          BIT_POL0   = 1;
    localparam int          BIT_EN0    = 0;
    localparam logic [15:0] CTRL_WMASK = 16'hcfff;
    localparam logic [15:0] RST_CTRL   = 16'h0000;
    localparam logic [15:0] RST_OUT    = 16'h0000;
    localparam logic [15:0] RST_DIR    = 16'h0000;

    // ------------------------------------------------------------
    // Pin numbers
    // ------------------------------------------------------------
    localparam int PIN_TXEN  = 30;
    localparam int PIN_EXT_INTERRUPT_ONE  = 25;
    localparam int PIN_EXT_INTERRUPT_ZERO  = 24;
    localparam int PIN_SS_A  = 9;
    localparam int PIN_SS_B  = 15;

    typedef enum logic [2:0] {
        MODE_PLAIN = 3'b000,
        MODE_IDE   = 3'b100,
        MODE_HOST  = 3'b101,
        MODE_SCAN  = 3'b110
    } gpr_mode_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } gpr_bus_t;

    typedef struct packed {
        logic fs_pin;
        logic fs_bus;
        logic spi_pin;
        logic spi_bus;
        logic ss_pin15;
        logic ss_pin9;
        logic ss_bus9;
        logic tx_route;
    } gpr_route_t;

endpackage

// ==== gpr_edge.sv ====
`timescale 1ns/1ps
module gpr_edge
    import gpr_pkg::*;
(
    // Clock and reset
    input  wire logic CLK,
    input  wire logic RST,
    // Pin and control
    input  wire logic pin,
    input  wire logic rising,
    input  wire logic enable,
    // Event
    output logic      pulse
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic [1:0] fill;
        logic pulse;
    } gpr_edge_st_t;

    gpr_edge_st_t st_q;
    gpr_edge_st_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = pin;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // History holds real pin levels only after three clocks; a cleared stage must not look like an edge
        st_d.fill = (&st_q.fill) ? st_q.fill : st_q.fill + 2'd1;
        st_d.pulse = enable && (&st_q.fill) &&
                     (rising ? (st_q.s2 && !st_q.s3) : (!st_q.s2 && st_q.s3));
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pulse = st_q.pulse;

    edge_one_a: assert property (@(posedge CLK) disable iff (RST) st_q.pulse |=> !st_q.pulse) else $error("edge pulse longer than one cycle");
    edge_cause_a: assert property (@(posedge CLK) disable iff (RST)
        st_q.pulse |-> $past(enable) && ($past(rising) ? $past(st_q.s2, 1) : !$past(st_q.s2, 1)))
        else $error("edge pulse without qualifying edge");
endmodule

// ==== gpr_regs.sv ====
`timescale 1ns/1ps
module gpr_regs
    import gpr_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // Register port
    input  wire gpr_bus_t    bus,
    input  wire logic [31:0] pins_in,
    // Register contents
    output logic [15:0]      ctrl,
    output logic [31:0]      out_data,
    output logic [31:0]      dir,
    output logic [15:0]      rdata
);
    typedef struct packed {
        logic [15:0] ctrl;
        logic [31:0] out_data;
        logic [31:0] dir;
        logic        lock;
        logic [15:0] rdata;
    } gpr_regs_st_t;

    gpr_regs_st_t st_q;
    gpr_regs_st_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.rdata = 16'h0000;
        if (bus.wr) begin
            case (bus.addr)
                OFS_CTRL: begin
                    if (st_q.lock) begin
                        st_d.ctrl[7:0] = bus.wdata[7:0];
                    end else begin
                        st_d.ctrl = bus.wdata & CTRL_WMASK;
                        st_d.lock = bus.wdata[BIT_WP];
                    end
                end
                OFS_OUT0: st_d.out_data[15:0]  = bus.wdata;
                OFS_OUT1: st_d.out_data[31:16] = bus.wdata;
                OFS_DIR0: st_d.dir[15:0]       = bus.wdata;
                OFS_DIR1: st_d.dir[31:16]      = bus.wdata;
                default: st_d.ctrl = st_d.ctrl;
            endcase
        end
        if (bus.rd) begin
            case (bus.addr)
                OFS_CTRL: st_d.rdata = st_q.ctrl;
                OFS_OUT0: st_d.rdata = st_q.out_data[15:0];
                OFS_OUT1: st_d.rdata = st_q.out_data[31:16];
                OFS_IN0:  st_d.rdata = pins_in[15:0];
                OFS_IN1:  st_d.rdata = pins_in[31:16];
                OFS_DIR0: st_d.rdata = st_q.dir[15:0];
                OFS_DIR1: st_d.rdata = st_q.dir[31:16];
                default:  st_d.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign ctrl     = st_q.ctrl;
    assign out_data = st_q.out_data;
    assign dir      = st_q.dir;
    assign rdata    = st_q.rdata;

    lock_hold_a: assert property (@(posedge CLK) disable iff (RST)
        st_q.lock |=> st_q.ctrl[15:8] == $past(st_q.ctrl[15:8])) else $error("locked byte changed");
    out_read_a: assert property (@(posedge CLK) disable iff (RST)
        bus.rd && bus.addr == OFS_OUT0 |=> st_q.rdata == $past(st_q.out_data[15:0]))
        else $error("output data readback wrong");
    in_read_a: assert property (@(posedge CLK) disable iff (RST)
        bus.rd && bus.addr == OFS_IN1 |=> st_q.rdata == $past(pins_in[31:16]))
        else $error("input data read wrong");
endmodule

// ==== gpr_top.sv ====
// Added by the designer: strobed register access.
`timescale 1ns/1ps
// Operation
// - Write-protect bit locks control upper byte until chip reset.
// - Transmitter-route bit drives port transmitter enable onto pin 30.
// - Select-reroute moves SPI slave select from pin 9 to pin 15.
// - Mode field sets use of pins 15..0 and 24..19.
// - Fast serial pin-route connects port to pins 26, 18..16.
// - Fast serial bus-route uses memory data 15..12, beats pin-route.
// - SPI pin-route connects SPI to pins 11..8.
// - SPI bus-route uses memory data 11..8, beats both other bits.
// - Interrupt one from pin 25, interrupt zero from pin 24.
// - Interrupt one on rising edge if polarity set, else falling.
// - Interrupt one needs local enable and processor pin-interrupt enable.
// - Interrupt zero on rising edge if polarity set, else falling.
// - Interrupt zero needs local enable and processor pin-interrupt enable.
// - Pins 15..0 from first output bank, 31..16 from second.
// - Output data read returns last written value.
// - Seven pin registers decoded at listed addresses.
// - Direction bit one makes pin output, zero makes input.
// - Input data read returns present pin levels.
module gpr_top
    import gpr_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // Register port
    input  wire logic [15:0] ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [15:0]      RDATA,
    // Pins
    input  wire logic [31:0] PIN_I,
    output logic [31:0]      PIN_O,
    output logic [31:0]      PIN_OE,
    // Processor and port status
    input  wire logic        CPU_PIN_IRQ_EN,
    input  wire logic        PORT_TX_EN,
    // Interrupt events
    output logic             EXT_EXT_INTERRUPT_ZERO,
    output logic             EXT_EXT_INTERRUPT_ONE,
    // Routing selects
    output logic [2:0]       PIN_MODE,
    output gpr_route_t       ROUTE
);
    typedef struct packed {
        logic [31:0] pin_o;
        logic [31:0] pin_oe;
        logic [2:0]  mode;
        gpr_route_t  route;
    } gpr_top_st_t;

    gpr_top_st_t st_q;
    gpr_top_st_t st_d;
    gpr_bus_t    bus;
    logic [15:0] ctrl;
    logic [31:0] out_data;
    logic [31:0] dir;
    logic        ext_interrupt_zero;
    logic        ext_interrupt_one;

    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    gpr_regs u_regs (
        .CLK      (CLK),
        .RST      (RST),
        .bus      (bus),
        .pins_in  (PIN_I),
        .ctrl     (ctrl),
        .out_data (out_data),
        .dir      (dir),
        .rdata    (RDATA)
    );

    // ------------------------------------------------------------
    // External interrupts
    // ------------------------------------------------------------
    gpr_edge u_ext_interrupt_zero (
        .CLK    (CLK),
        .RST    (RST),
        .pin    (PIN_I[PIN_EXT_INTERRUPT_ZERO]),
        .rising (ctrl[BIT_POL0]),
        .enable (ctrl[BIT_EN0] && CPU_PIN_IRQ_EN),
        .pulse  (ext_interrupt_zero)
    );

    gpr_edge u_ext_interrupt_one (
        .CLK    (CLK),
        .RST    (RST),
        .pin    (PIN_I[PIN_EXT_INTERRUPT_ONE]),
        .rising (ctrl[BIT_POL1]),
        .enable (ctrl[BIT_EN1] && CPU_PIN_IRQ_EN),
        .pulse  (ext_interrupt_one)
    );

    assign EXT_EXT_INTERRUPT_ZERO = ext_interrupt_zero;
    assign EXT_EXT_INTERRUPT_ONE = ext_interrupt_one;

    // ------------------------------------------------------------
    // Routing and pin drive
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.pin_o  = out_data;
        st_d.pin_oe = dir;
        st_d.mode   = ctrl[MODE_LO +: 3];
        st_d.route.fs_bus   = ctrl[BIT_HSBUS];
        st_d.route.fs_pin   = ctrl[BIT_HSPIN] && !ctrl[BIT_HSBUS];
        st_d.route.spi_bus  = ctrl[BIT_SPIBUS];
        st_d.route.spi_pin  = ctrl[BIT_SPIPIN] && !ctrl[BIT_SPIBUS];
        st_d.route.ss_pin15 = ctrl[BIT_SAS] && !ctrl[BIT_SPIBUS];
        st_d.route.ss_pin9  = ctrl[BIT_SPIPIN] && !ctrl[BIT_SAS] && !ctrl[BIT_SPIBUS];
        st_d.route.ss_bus9  = ctrl[BIT_SPIBUS];
        st_d.route.tx_route = ctrl[BIT_TXR];
        if (ctrl[BIT_TXR]) begin
            st_d.pin_o[PIN_TXEN]  = PORT_TX_EN;
            st_d.pin_oe[PIN_TXEN] = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign PIN_O    = st_q.pin_o;
    assign PIN_OE   = st_q.pin_oe;
    assign PIN_MODE = st_q.mode;
    assign ROUTE    = st_q.route;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    tx_route_a: assert property (@(posedge CLK) disable iff (RST)
        ctrl[BIT_TXR] |=> PIN_O[PIN_TXEN] == $past(PORT_TX_EN) && PIN_OE[PIN_TXEN])
        else $error("transmitter enable not on pin 30");
    ss_move_a: assert property (@(posedge CLK) disable iff (RST)
        ctrl[BIT_SAS] && !ctrl[BIT_SPIBUS] |=> ROUTE.ss_pin15 && !ROUTE.ss_pin9)
        else $error("select not moved to pin 15");
    fs_prio_a: assert property (@(posedge CLK) disable iff (RST)
        ctrl[BIT_HSBUS] |=> ROUTE.fs_bus && !ROUTE.fs_pin) else $error("fast serial priority wrong");
    fs_pin_a: assert property (@(posedge CLK) disable iff (RST)
        ctrl[BIT_HSPIN] && !ctrl[BIT_HSBUS] |=> ROUTE.fs_pin) else $error("fast serial pin route missing");
    spi_prio_a: assert property (@(posedge CLK) disable iff (RST)
        ctrl[BIT_SPIBUS] |=> ROUTE.spi_bus && !ROUTE.spi_pin && !ROUTE.ss_pin15)
        else $error("spi bus priority wrong");
    spi_pin_a: assert property (@(posedge CLK) disable iff (RST)
        ctrl[BIT_SPIPIN] && !ctrl[BIT_SPIBUS] |=> ROUTE.spi_pin) else $error("spi pin route missing");
    mode_out_a: assert property (@(posedge CLK) disable iff (RST)
        1'b1 |=> PIN_MODE == $past(ctrl[10:8])) else $error("mode field not applied");
    drive_bank_a: assert property (@(posedge CLK) disable iff (RST)
        !ctrl[BIT_TXR] |=> PIN_O == $past(out_data) && PIN_OE == $past(dir))
        else $error("pin drive does not follow banks");
    irq_gate_a: assert property (@(posedge CLK) disable iff (RST)
        !CPU_PIN_IRQ_EN [*2] |=> !EXT_EXT_INTERRUPT_ZERO && !EXT_EXT_INTERRUPT_ONE) else $error("interrupt raised while disabled");
endmodule

// ==== gpr_pin_model.sv ====
`timescale 1ns/1ps
module gpr_pin_model (
    // Clock
    input  wire logic        CLK,
    // Design side of each pin
    input  wire logic [31:0] pin_o,
    input  wire logic [31:0] pin_oe,
    // Outside drivers
    input  wire logic [31:0] ext_en,
    input  wire logic [31:0] ext_val,
    // Resolved pin levels
    output logic [31:0]      pin_level
);
    logic [31:0] float_q = 32'h0000_0000;

    // Nobody drives a pin released by both sides, so its level wanders every cycle
    always_ff @(posedge CLK) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            pin_level[i] = pin_oe[i] ? pin_o[i] : (ext_en[i] ? ext_val[i] : float_q[i]);
        end
    end
endmodule

// ==== gpio_pin_routing_and_irq_tb_top.sv ====
`timescale 1ns/1ps
module gpio_pin_routing_and_irq_tb_top;
    import gpr_pkg::*;
    logic        CLK, RST, WR, RD, CPU_PIN_IRQ_EN, PORT_TX_EN, EXT_EXT_INTERRUPT_ZERO, EXT_EXT_INTERRUPT_ONE;
    logic [15:0] ADDR, WDATA, RDATA;
    logic [31:0] PIN_I, PIN_O, PIN_OE, ext_en, ext_val;
    logic [2:0]  PIN_MODE;
    gpr_route_t  ROUTE;
    int          num_errors = 0;
    int          compares   = 0;

    gpr_top uut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE(PIN_OE), .CPU_PIN_IRQ_EN(CPU_PIN_IRQ_EN),
        .PORT_TX_EN(PORT_TX_EN), .EXT_EXT_INTERRUPT_ZERO(EXT_EXT_INTERRUPT_ZERO), .EXT_EXT_INTERRUPT_ONE(EXT_EXT_INTERRUPT_ONE), .PIN_MODE(PIN_MODE), .ROUTE(ROUTE));
    gpr_pin_model far (.CLK(CLK), .pin_o(PIN_O), .pin_oe(PIN_OE), .ext_en(ext_en), .ext_val(ext_val),
        .pin_level(PIN_I));

    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [15:0] a, input logic [15:0] exp);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        check(what, {16'h0000, exp}, {16'h0000, RDATA});
    endtask

    task automatic settle;
        @(posedge CLK);
        #1;
    endtask

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values;
        logic [15:0] regs [7] = '{OFS_CTRL, OFS_OUT0, OFS_IN0, OFS_DIR0, OFS_OUT1, OFS_IN1, OFS_DIR1};
        for (int i = 0; i < 7; i++) begin
            rd_chk("reset value", regs[i], 16'h0000);
        end
        check("PIN_OE", 32'h0, PIN_OE);
        check("ROUTE", 32'h0, 32'(ROUTE));
    endtask

    task automatic t_data_dir;
        @(posedge CLK);
        ext_val <= 32'h3c00_0000;
        bus_wr(OFS_OUT0, 16'ha5c3);
        bus_wr(OFS_OUT1, 16'h5a3c);
        bus_wr(OFS_DIR0, 16'hffff);
        bus_wr(OFS_DIR1, 16'h00ff);
        settle;
        check("PIN_O", 32'h5a3c_a5c3, PIN_O);
        check("PIN_OE", 32'h00ff_ffff, PIN_OE);
        rd_chk("out1", OFS_OUT1, 16'h5a3c);
        rd_chk("in0", OFS_IN0, 16'ha5c3);
        rd_chk("in1", OFS_IN1, 16'h3c3c);
        rd_chk("dir1", OFS_DIR1, 16'h00ff);
        bus_wr(OFS_IN0, 16'h1234);
        bus_wr(16'hc008, 16'hffff);
        rd_chk("unmapped", 16'hc008, 16'h0000);
        rd_chk("in0 kept", OFS_IN0, 16'ha5c3);
        bus_wr(OFS_DIR0, 16'h0000);
        settle;
        check("PIN_OE", 32'h00ff_0000, PIN_OE);
    endtask

    task automatic t_modes;
        gpr_mode_t m [4] = '{MODE_PLAIN, MODE_IDE, MODE_HOST, MODE_SCAN};
        for (int i = 0; i < 4; i++) begin
            bus_wr(OFS_CTRL, {5'h00, m[i], 8'h00});
            settle;
            check("PIN_MODE", 32'(m[i]), 32'(PIN_MODE));
            rd_chk("ctrl mode", OFS_CTRL, {5'h00, m[i], 8'h00});
        end
        bus_wr(OFS_CTRL, 16'h3000);
        rd_chk("ctrl reserved", OFS_CTRL, 16'h0000);
    endtask

    task automatic t_routes;
        logic [15:0] c [6] = '{16'h0080, 16'h00c0, 16'h0020, 16'h0820, 16'h0830, 16'h4000};
        logic [7:0]  r [6] = '{8'h80, 8'h40, 8'h24, 8'h28, 8'h12, 8'h01};
        for (int i = 0; i < 6; i++) begin
            bus_wr(OFS_CTRL, c[i]);
            settle;
            check("ROUTE", 32'(r[i]), 32'(ROUTE));
        end
    endtask

    task automatic t_tx_route;
        @(posedge CLK);
        PORT_TX_EN <= 1'b1;
        settle;
        check("pin 30 out/oe", 32'h3, {30'h0, PIN_O[30], PIN_OE[30]});
        @(posedge CLK);
        PORT_TX_EN <= 1'b0;
        settle;
        check("pin 30 out/oe", 32'h1, {30'h0, PIN_O[30], PIN_OE[30]});
        bus_wr(OFS_CTRL, 16'h0000);
        settle;
        check("pin 30 oe", 32'h0, 32'(PIN_OE[30]));
    endtask

    task automatic count_pulses(output logic [31:0] n0, output logic [31:0] n1);
        n0 = 32'h0;
        n1 = 32'h0;
        repeat (10) begin
            @(posedge CLK);
            #1;
            n0 = n0 + 32'(EXT_EXT_INTERRUPT_ZERO);
            n1 = n1 + 32'(EXT_EXT_INTERRUPT_ONE);
        end
    endtask

    task automatic irq_case(input int line, input logic pol, input logic loc, input logic cpu, input int exp);
        logic [31:0] n0, n1;
        @(posedge CLK);
        ext_val[24 + line] <= ~pol;
        CPU_PIN_IRQ_EN <= cpu;
        repeat (8) @(posedge CLK);
        bus_wr(OFS_CTRL, 16'({pol, loc}) << (2 * line));
        @(posedge CLK);
        ext_val[24 + line] <= pol;
        count_pulses(n0, n1);
        check("irq pulses", 32'(exp), line ? n1 : n0);
        check("irq other line", 32'h0, line ? n0 : n1);
        @(posedge CLK);
        ext_val[24 + line] <= ~pol;
        count_pulses(n0, n1);
        check("irq opposite edge", 32'h0, n0 + n1);
    endtask

    task automatic t_lock;
        bus_wr(OFS_CTRL, 16'h84a5);
        bus_wr(OFS_CTRL, 16'h0d5a);
        rd_chk("ctrl locked", OFS_CTRL, 16'h845a);
        check("PIN_MODE", 32'h4, 32'(PIN_MODE));
        @(posedge CLK);
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        rd_chk("ctrl after reset", OFS_CTRL, 16'h0000);
        rd_chk("out0 after reset", OFS_OUT0, 16'h0000);
        bus_wr(OFS_CTRL, 16'h0500);
        rd_chk("ctrl unlocked", OFS_CTRL, 16'h0500);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        RST = 1'b1;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 16'h0000;
        WDATA = 16'h0000;
        CPU_PIN_IRQ_EN = 1'b0;
        PORT_TX_EN = 1'b0;
        ext_en = 32'hffff_ffff;
        ext_val = 32'h0000_0000;
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        t_reset_values();
        t_data_dir();
        t_modes();
        t_routes();
        t_tx_route();
        for (int l = 0; l < 2; l++) begin
            irq_case(l, 1'b1, 1'b1, 1'b1, 1);
            irq_case(l, 1'b0, 1'b1, 1'b1, 1);
            irq_case(l, 1'b1, 1'b1, 1'b0, 0);
            irq_case(l, 1'b1, 1'b0, 1'b1, 0);
        end
        t_lock();
        end_of_test();
    end

    // Cuts a hung run short
    initial begin
        repeat (20000) @(posedge CLK);
        num_errors++;
        $display("[FAIL] run length expected under 20000 cycles seen more");
        end_of_test();
    end
endmodule
